// File: inc/fdc_seq_defs.svh
`ifndef FDC_SEQ_DEFS_SVH
`define FDC_SEQ_DEFS_SVH
// Controller port map
`define PORT_CMD_STAT      8'h10
`define PORT_TRACK         8'h11
`define PORT_SECTOR        8'h12
`define PORT_DATA          8'h13
// System control register port
`define PORT_SYSCTL        8'h18
// Geometry
`define SECTOR_BYTES       512
`define SECTORS_PER_TRACK  10
`define CYLINDERS          80
`define SIDES              2
`define LOG_BYTES          128
`define LOG_PER_PHYS       4
// Command codes
`define CMD_RESTORE        8'h0C
`define CMD_SEEK           8'h1C
`define CMD_STEP_IN        8'h5C
`define CMD_READ_SECTOR    8'h82
`define CMD_WRITE_SECTOR   8'hA2
`define CMD_WRITE_TRACK    8'hF0
`define CMD_FORCE_TERM     8'hD0
// Status timeout flag position
`define STAT_TIMEOUT_BIT   7
// Timing
`define CLK_MHZ            125
`define SETTLE_US          1000
`define SETTLE_CYCLES      (`SETTLE_US * `CLK_MHZ)
`define TIMEOUT_CYCLES     250000000
`define IO_STROBE_CYCLES   4
`endif

// File: inc/fdc_seq_pkg.sv
package fdc_seq_pkg;
   // Operation selector
   typedef enum logic [2:0] {
      OP_RESTORE, OP_SEEK, OP_STEP_IN, OP_READ, OP_WRITE, OP_FORMAT, OP_SELECT
   } op_t;

   // Request from the user side
   typedef struct packed {
      op_t         op;
      logic [6:0]  track;
      logic [3:0]  sector;
      logic [2:0]  sel_bits;
      logic [15:0] buf_addr;
      logic        settle_pre;
      logic        settle_post;
   } req_t;

   // I/O bus cycle toward the controller
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } io_t;

   // Buffer memory port
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } mem_t;
endpackage

// File: rtl/format_byte_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "fdc_seq_defs.svh"
// Format stream: yields byte at stream index for given track, side
module format_byte_gen
   import fdc_seq_pkg::*;
(
   // Position
   input  wire logic [15:0] idx_i,
   input  wire logic [6:0]  track_i,
   input  wire logic        side_i,
   // Result
   output logic [7:0]       byte_o,
   output logic             last_o
);
   localparam int PRE    = 116;   // 50+12+3+1+50
   localparam int SECLEN = 604;   // bracketed field: 59 head, 512 data, F7, 32 gap
   localparam int TAIL   = 680;
   localparam int TOTAL  = PRE + `SECTORS_PER_TRACK * SECLEN + TAIL;

   int rel;
   int sec;
   int off;

   // Decode position into preamble, sector field or tail
   always_comb begin
      rel    = 0;
      sec    = 0;
      off    = 0;
      byte_o = 8'h4E;
      last_o = (int'(idx_i) == TOTAL - 1);
      if (int'(idx_i) < 50)       byte_o = 8'h4E;
      else if (int'(idx_i) < 62)  byte_o = 8'h00;
      else if (int'(idx_i) < 65)  byte_o = 8'hF6;
      else if (int'(idx_i) < 66)  byte_o = 8'hFC;
      else if (int'(idx_i) < PRE) byte_o = 8'h4E;
      else if (int'(idx_i) < PRE + `SECTORS_PER_TRACK * SECLEN) begin
         rel = int'(idx_i) - PRE;
         sec = rel / SECLEN;
         off = rel % SECLEN;
         if (off < 12)        byte_o = 8'h00;
         else if (off < 15)   byte_o = 8'hF5;
         else if (off == 15)  byte_o = 8'hFE;
         else if (off == 16)  byte_o = {1'b0, track_i};
         else if (off == 17)  byte_o = {7'h00, side_i};
         else if (off == 18)  byte_o = 8'(sec + 1);
         else if (off == 19)  byte_o = 8'h02;
         else if (off == 20)  byte_o = 8'hF7;
         else if (off < 43)   byte_o = 8'h4E;
         else if (off < 55)   byte_o = 8'h00;
         else if (off < 58)   byte_o = 8'hF5;
         else if (off == 58)  byte_o = 8'hFB;
         else if (off < 571)  byte_o = 8'hE5;
         else if (off == 571) byte_o = 8'hF7;
         else                 byte_o = 8'h4E;
      end
   end
endmodule // format_byte_gen
`default_nettype wire

// File: rtl/fdc_host_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "fdc_seq_defs.svh"
// Function
// - A diskette is 512-byte sectors, 10 per track, two sides, 80 cylinders.
// - Formatting issues track-write then the preamble 50x4E, 12x00, 3xF6, 1xFC.
// - The per-sector field with FE id mark and F7 crc marker repeats for 10 sectors.
// - Id track byte is 00..4F and side byte 00..01, matching head and side.
// - Seek is preceded by writing the target track to data port 13H.
// - An optional 1 ms settle wait may come before and after positioning.
// - An unfinished command is force-terminated and status returns with D7 set.
// - Selection alters only the three low system control bits.
// - Selection is a read-modify-write of a shadow copy, then written out.
// - Reads use 82 and writes A2, after the sector is loaded; the track register is not written.
// - Data bytes move per byte request between data port and buffer.
// - Controller ports are 10H command/status, 11H track, 12H sector, 13H data.
module fdc_host_seq
   import fdc_seq_pkg::*;
#(
   parameter int TIMEOUT_CYC = `TIMEOUT_CYCLES,
   parameter int SETTLE_CYC  = `SETTLE_CYCLES
)(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   // User request and answer
   input  wire logic        req_valid_i,
   input  var  req_t        req_i,
   output logic             busy_o,
   output logic             done_o,
   output logic [7:0]       status_o,
   // Controller I/O bus
   output var  io_t         io_o,
   input  wire logic [7:0]  io_rdata_i,
   input  wire logic        byte_request_i,
   input  wire logic        command_done_irq_i,
   // Buffer memory
   output var  mem_t        mem_o,
   input  wire logic [7:0]  mem_rdata_i
);
   typedef enum logic [3:0] {
      S_IDLE, S_PRE, S_IO, S_IO_WAIT, S_WAIT_IRQ, S_MEM, S_POST, S_STAT, S_DONE
   } state_t;

   // Sequencer state
   state_t      st_q, st_d, ret_q, ret_d;
   req_t        rq_q, rq_d;
   io_t         io_q, io_d;
   mem_t        mem_q, mem_d;
   logic [7:0]  shadow_q, shadow_d;
   logic [7:0]  stat_q, stat_d;
   logic [7:0]  rdat_q, rdat_d;
   logic        busy_q, busy_d, done_q, done_d, tmo_q, tmo_d;
   logic [2:0]  step_q, step_d;
   logic [31:0] tmr_q, tmr_d;
   logic [15:0] cnt_q, cnt_d;
   logic [2:0]  strb_q, strb_d;
   logic        rd_dir_q, rd_dir_d;
   logic [7:0]  fmt_byte;
   logic        fmt_last;

   // Build one port access: a read if rd is set, else a write
   function automatic io_t io_cycle(input logic rd, input logic [7:0] a, input logic [7:0] d);
      io_t r;
      r.rd    = rd;
      r.wr    = ~rd;
      r.addr  = a;
      r.wdata = d;
      return r;
   endfunction

   // Buffer offset: four 128-byte logical slots make one 512-byte sector
   function automatic logic [15:0] buf_offset(input logic [15:0] n);
      logic [1:0] slot;
      logic [6:0] byte_in;
      slot    = n[8:7];
      byte_in = n[6:0];
      return 16'({slot, byte_in});
   endfunction

   format_byte_gen u_fmt (
      .idx_i   (cnt_q),
      .track_i (rq_q.track),
      .side_i  (shadow_q[1]),
      .byte_o  (fmt_byte),
      .last_o  (fmt_last)
   );

   // Next state
   always_comb begin
      st_d = st_q; ret_d = ret_q; rq_d = rq_q; io_d = io_q; mem_d = mem_q;
      shadow_d = shadow_q; stat_d = stat_q; busy_d = busy_q; done_d = 1'b0;
      tmo_d = tmo_q; step_d = step_q; tmr_d = tmr_q; cnt_d = cnt_q;
      strb_d = strb_q; rd_dir_d = rd_dir_q; rdat_d = rdat_q;
      mem_d.rd = 1'b0; mem_d.wr = 1'b0;
      case (st_q)
         S_IDLE: begin
            if (req_valid_i) begin
               rq_d = req_i; busy_d = 1'b1; tmo_d = 1'b0; step_d = 3'd0;
               tmr_d = 32'd0; cnt_d = 16'd0;
               st_d = req_i.settle_pre ? S_PRE : S_STAT;
               if (req_i.settle_pre) ret_d = S_STAT;
               // Selection bypasses settling and goes to done after one control port write
               if (req_i.op == OP_SELECT) begin
                  shadow_d = {shadow_q[7:3], req_i.sel_bits};
                  io_d = io_cycle(1'b0, `PORT_SYSCTL, {shadow_q[7:3], req_i.sel_bits});
                  st_d = S_IO; ret_d = S_DONE; strb_d = 3'd0;
               end
            end
         end
         S_PRE: begin
            tmr_d = tmr_q + 32'd1;
            if (tmr_q >= 32'(SETTLE_CYC - 1)) begin
               tmr_d = 32'd0; st_d = S_STAT;
            end
         end
         S_STAT: begin
            // Step dispatcher per operation
            strb_d = 3'd0; st_d = S_IO; step_d = step_q + 3'd1; ret_d = S_STAT;
            case (rq_q.op)
               OP_SEEK: begin
                  if (step_q == 3'd0)
                     io_d = io_cycle(1'b0, `PORT_DATA, {1'b0, rq_q.track});
                  else begin
                     io_d = io_cycle(1'b0, `PORT_CMD_STAT, `CMD_SEEK);
                     ret_d = S_WAIT_IRQ;
                  end
               end
               OP_RESTORE, OP_STEP_IN: begin
                  io_d = io_cycle(1'b0, `PORT_CMD_STAT,
                                  rq_q.op == OP_RESTORE ? `CMD_RESTORE : `CMD_STEP_IN);
                  ret_d = S_WAIT_IRQ;
               end
               OP_READ, OP_WRITE: begin
                  if (step_q == 3'd0)
                     io_d = io_cycle(1'b0, `PORT_SECTOR, {4'h0, rq_q.sector});
                  else begin
                     io_d = io_cycle(1'b0, `PORT_CMD_STAT, rq_q.op == OP_READ ?
                                     `CMD_READ_SECTOR : `CMD_WRITE_SECTOR);
                     ret_d = S_WAIT_IRQ;
                  end
               end
               default: begin                       // Format
                  io_d = io_cycle(1'b0, `PORT_CMD_STAT, `CMD_WRITE_TRACK);
                  ret_d = S_WAIT_IRQ;
               end
            endcase
         end
         S_IO: begin
            // Hold the strobe a few cycles
            strb_d = strb_q + 3'd1;
            if (strb_q == 3'(`IO_STROBE_CYCLES - 1)) begin
               if (io_q.rd) rdat_d = io_rdata_i;   // Status held back until done
               io_d.rd = 1'b0; io_d.wr = 1'b0; st_d = ret_q;
            end
         end
         S_WAIT_IRQ: begin
            tmr_d = tmr_q + 32'd1;
            if (command_done_irq_i) begin
               io_d = io_cycle(1'b1, `PORT_CMD_STAT, 8'h00);
               strb_d = 3'd0; tmr_d = 32'd0;
               st_d = S_IO; ret_d = rq_q.settle_post ? S_POST : S_DONE;
            end else if (tmr_q >= 32'(TIMEOUT_CYC - 1)) begin
               io_d = io_cycle(1'b0, `PORT_CMD_STAT, `CMD_FORCE_TERM);
               tmo_d = 1'b1; strb_d = 3'd0; step_d = 3'd7; st_d = S_IO; ret_d = S_IO_WAIT;
            end else if (byte_request_i && rq_q.op != OP_SEEK && rq_q.op != OP_RESTORE
                         && rq_q.op != OP_STEP_IN) begin
               strb_d = 3'd0;
               if (rq_q.op == OP_READ) begin
                  io_d = io_cycle(1'b1, `PORT_DATA, 8'h00);
                  rd_dir_d = 1'b1; st_d = S_IO; ret_d = S_MEM;
               end else if (rq_q.op == OP_WRITE) begin
                  mem_d.rd = 1'b1; mem_d.addr = rq_q.buf_addr + buf_offset(cnt_q);
                  rd_dir_d = 1'b0; st_d = S_MEM;
               end else begin
                  io_d = io_cycle(1'b0, `PORT_DATA, fmt_byte);
                  cnt_d = fmt_last ? cnt_q : cnt_q + 16'd1;
                  st_d = S_IO; ret_d = S_IO_WAIT;
               end
            end
         end
         S_MEM: begin
            // Complete one buffered byte, address from base plus count
            if (rd_dir_q) begin
               mem_d.wr = 1'b1; mem_d.addr = rq_q.buf_addr + buf_offset(cnt_q);
               mem_d.wdata = rdat_q;
               cnt_d = cnt_q + 16'd1; st_d = S_IO_WAIT;
            end else begin
               io_d = io_cycle(1'b0, `PORT_DATA, mem_rdata_i);
               cnt_d = cnt_q + 16'd1; strb_d = 3'd0; st_d = S_IO; ret_d = S_IO_WAIT;
            end
         end
         S_IO_WAIT: begin
            // Wait for request to drop before next byte; after abort read status
            if (tmo_q && step_q == 3'd7) begin
               io_d = io_cycle(1'b1, `PORT_CMD_STAT, 8'h00);
               step_d = 3'd0; strb_d = 3'd0; st_d = S_IO; ret_d = S_DONE;
            end else if (!byte_request_i || command_done_irq_i) st_d = S_WAIT_IRQ;
         end
         S_POST: begin
            tmr_d = tmr_q + 32'd1;
            if (tmr_q >= 32'(SETTLE_CYC - 1)) st_d = S_DONE;
         end
         S_DONE: begin
            stat_d = rdat_q;
            if (tmo_q) stat_d[`STAT_TIMEOUT_BIT] = 1'b1;
            if (rq_q.op == OP_SELECT) stat_d = shadow_q;
            busy_d = 1'b0; done_d = 1'b1; st_d = S_IDLE;
         end
         default: st_d = S_IDLE;
      endcase
   end

   // State registers
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_q <= S_IDLE; ret_q <= S_IDLE; rq_q <= '0; io_q <= '0; mem_q <= '0;
         shadow_q <= 8'h00; stat_q <= 8'h00; busy_q <= 1'b0; done_q <= 1'b0;
         tmo_q <= 1'b0; step_q <= 3'd0; tmr_q <= 32'd0; cnt_q <= 16'd0;
         strb_q <= 3'd0; rd_dir_q <= 1'b0; rdat_q <= 8'h00;
      end else begin
         st_q <= st_d; ret_q <= ret_d; rq_q <= rq_d; io_q <= io_d; mem_q <= mem_d;
         shadow_q <= shadow_d; stat_q <= stat_d; busy_q <= busy_d; done_q <= done_d;
         tmo_q <= tmo_d; step_q <= step_d; tmr_q <= tmr_d; cnt_q <= cnt_d;
         strb_q <= strb_d; rd_dir_q <= rd_dir_d; rdat_q <= rdat_d;
      end
   end

   // Outputs straight from flops
   assign busy_o   = busy_q;
   assign done_o   = done_q;
   assign status_o = stat_q;
   assign io_o     = io_q;
   assign mem_o    = mem_q;
endmodule // fdc_host_seq
`default_nettype wire

// File: bench/fdc_host_seq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Checker on the sequencer ports
module fdc_host_seq_asserts
   import fdc_seq_pkg::*;
(
   // Clock, reset, request
   input wire logic       clk_i,
   input wire logic       nrst_i,
   input wire logic       req_valid_i,
   // Answers and buses
   input wire logic       busy_o,
   input wire logic       done_o,
   input wire logic [7:0] status_o,
   input var  io_t        io_o,
   input var  mem_t       mem_o
);
   logic [7:0] prev_q;
   logic [7:0] sys_q;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // Last port written and last control value
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         prev_q <= 8'h00;
         sys_q  <= 8'h00;
      end else if ($rose(io_o.wr)) begin
         prev_q <= io_o.addr;
         if (io_o.addr == 8'h18) sys_q <= io_o.wdata;
      end
   end
   sequence s_wr_hold;
      (io_o.wr && $stable(io_o.addr) && $stable(io_o.wdata)) [*3];
   endsequence
   sequence s_rd_hold;
      (io_o.rd && $stable(io_o.addr)) [*3];
   endsequence
   a_done_pulse: assert property (done_o |=> !done_o)
      else $error("done wider than one cycle");
   a_take_busy: assert property (!busy_o && req_valid_i |=> busy_o)
      else $error("request not taken");
   a_stat_hold: assert property (!done_o |-> $stable(status_o))
      else $error("status moved without done");
   a_wr_strobe: assert property ($rose(io_o.wr) |=> s_wr_hold)
      else $error("write strobe too short");
   a_rd_strobe: assert property ($rose(io_o.rd) |=> s_rd_hold)
      else $error("read strobe too short");
   a_port_map: assert property (io_o.wr || io_o.rd |->
      io_o.addr inside {8'h10, 8'h11, 8'h12, 8'h13, 8'h18})
      else $error("access outside port map");
   a_io_busy: assert property ($rose(io_o.wr) |-> busy_o)
      else $error("port write while idle");
   a_seek_data: assert property ($rose(io_o.wr) && io_o.addr == 8'h10 &&
      io_o.wdata == 8'h1C |-> prev_q == 8'h13)
      else $error("seek without target write");
   a_sel_low: assert property ($rose(io_o.wr) && io_o.addr == 8'h18 |->
      io_o.wdata[7:3] == sys_q[7:3])
      else $error("selection touched high bits");
   a_mem_pulse: assert property (mem_o.wr |=> !mem_o.wr)
      else $error("buffer write not one cycle");
endmodule // fdc_host_seq_asserts
bind fdc_host_seq fdc_host_seq_asserts chk (.clk_i(clk_i), .nrst_i(nrst_i),
   .req_valid_i(req_valid_i), .busy_o(busy_o), .done_o(done_o),
   .status_o(status_o), .io_o(io_o), .mem_o(mem_o));
`default_nettype wire

// File: bench/fdc_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural disk controller and drive
module fdc_ctl_model
   import fdc_seq_pkg::*;
(
   // Clock and bus
   input  wire logic       clk_i,
   input  var  io_t        io_i,
   input  wire logic       hang_i,
   // Answers
   output logic [7:0]      rdata_o,
   output logic            breq_o,
   output logic            irq_o
);
   logic [7:0] regs [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] last_q = 8'h00;
   logic       stb_q = 1'b0;
   int         left = 0;
   int         wait_n = 0;
   int         gap = 0;
   initial begin
      breq_o = 1'b0;
      irq_o  = 1'b0;
   end
   // Released bus shows inverse of last value
   assign rdata_o = io_i.rd ? regs[io_i.addr[1:0]] : ~last_q;
   always @(posedge clk_i) begin
      stb_q <= io_i.rd | io_i.wr;
      if (io_i.rd) last_q <= rdata_o;
      if (io_i.rd && !stb_q && io_i.addr == 8'h10) irq_o <= 1'b0;
      // Completion after a delay, withheld when stalled
      if (wait_n > 1) wait_n <= wait_n - 1;
      else if (wait_n == 1 && !hang_i) begin
         wait_n  <= 0;
         irq_o   <= 1'b1;
         regs[0] <= 8'h20;
      end
      // One data port access serves one request, prompt or slow
      if (breq_o && stb_q == 1'b0 && (io_i.rd || io_i.wr) && io_i.addr == 8'h13) begin
         breq_o <= 1'b0;
         left   <= left - 1;
         gap    <= left[0] ? 1 : 9;
         if (left == 1) wait_n <= 12;
      end else if (gap > 0) gap <= gap - 1;
      else if (!breq_o && left > 0 && !stb_q && !(io_i.rd || io_i.wr)) begin
         breq_o  <= 1'b1;
         regs[3] <= 8'(left);
      end
      // Register writes and commands
      if (io_i.wr && !stb_q && io_i.addr[7:2] == 6'h04) begin
         regs[io_i.addr[1:0]] <= io_i.wdata;
         if (io_i.addr == 8'h10) begin
            regs[0] <= 8'h01;
            case (io_i.wdata)
               8'h0C, 8'h5C: wait_n <= 30;
               8'h1C: begin
                  regs[1] <= regs[3];
                  wait_n  <= 30;
               end
               8'h82, 8'hA2: left <= 512;
               8'hF0: left <= 100000;
               8'hD0: begin
                  left   <= 0;
                  wait_n <= 0;
                  breq_o <= 1'b0;
                  irq_o  <= 1'b0;
               end
               default: ;
            endcase
         end
      end
   end
endmodule // fdc_ctl_model
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import fdc_seq_pkg::*;
;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        rv = 1'b0;
   logic        hang = 1'b0;
   logic        busy, done, breq, irq, wr_q;
   logic [7:0]  status, rdata, mrd;
   req_t        req;
   io_t         io;
   mem_t        mem;
   int          mismatches = 0;
   int          tests_run = 0;
   logic [23:0] mq[$];
   logic [15:0] wq[$], eq[$];
   always #4 clk = ~clk;
   fdc_host_seq #(.TIMEOUT_CYC(6000), .SETTLE_CYC(20)) uut (.clk_i(clk), .nrst_i(nrst),
      .req_valid_i(rv), .req_i(req), .busy_o(busy), .done_o(done), .status_o(status),
      .io_o(io), .io_rdata_i(rdata), .byte_request_i(breq), .command_done_irq_i(irq),
      .mem_o(mem), .mem_rdata_i(mrd));
   fdc_ctl_model ctl (.clk_i(clk), .io_i(io), .hang_i(hang), .rdata_o(rdata),
      .breq_o(breq), .irq_o(irq));
   // Log port and buffer writes; buffer answers reads
   always @(posedge clk) begin
      wr_q <= io.wr;
      if (io.wr && !wr_q) wq.push_back({io.addr, io.wdata});
      if (mem.wr) mq.push_back({mem.addr, mem.wdata});
   end
   // Buffer answers a read at once; idle it shows the inverse
   assign mrd = mem.rd ? (mem.addr[7:0] ^ 8'h5A) : ~(mem.addr[7:0] ^ 8'h5A);
   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic req_t mk(op_t op, int trk, int sec, int sel);
      mk = '{op, 7'(trk), 4'(sec), 3'(sel), 16'h0400, 1'b1, 1'b1};
   endfunction
   task automatic wait_done(output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (done !== 1'b1 && n < 20000);
      chk("done", 1, done);
   endtask
   task automatic run(input req_t r, output int n);
      @(posedge clk);
      req <= r;
      rv  <= 1'b1;
      @(posedge clk);
      rv <= 1'b0;
      wait_done(n);
   endtask
   task automatic add(input int n, input logic [7:0] v);
      repeat (n) eq.push_back({8'h13, v});
   endtask
   task automatic t_pos();
      int n;
      wq = {};
      run(mk(OP_RESTORE, 0, 1, 0), n);
      chk("restore", {8'h10, 8'h0C}, wq[0]);
      chk("status", 8'h20, status);
      run(mk(OP_STEP_IN, 0, 1, 0), n);
      chk("step", {8'h10, 8'h5C}, wq[1]);
      wq = {};
      run(mk(OP_SEEK, 40, 1, 0), n);
      chk("target", {8'h13, 8'd40}, wq[0]);
      chk("seek", {8'h10, 8'h1C}, wq[1]);
      chk("settle", 1, n > 40);
   endtask
   task automatic t_busy();
      int n;
      wq = {};
      @(posedge clk);
      req <= mk(OP_SEEK, 3, 1, 0);
      rv  <= 1'b1;
      @(posedge clk);
      req <= mk(OP_SELECT, 0, 1, 2);
      repeat (4) @(posedge clk);
      rv <= 1'b0;
      wait_done(n);
      run(mk(OP_SELECT, 0, 1, 6), n);
      chk("refused", {8'h18, 8'h06}, wq[2]);
      chk("shadow", 8'h06, status);
      run(mk(OP_SELECT, 0, 1, 5), n);
      chk("side", {8'h18, 8'h05}, wq[3]);
   endtask
   task automatic t_rw();
      int n;
      wq = {};
      mq = {};
      run(mk(OP_READ, 3, 5, 5), n);
      chk("read cmd", {8'h10, 8'h82}, wq[$]);
      chk("sector", {8'h12, 8'h05}, wq[$-1]);
      chk("count", 512, 24'(mq.size()));
      for (int i = 0; i < 512; i++)
         chk("rd byte", {16'h0400 + 16'(i), 8'(512 - i)}, mq[i]);
      wq = {};
      run(mk(OP_WRITE, 3, 5, 5), n);
      chk("write cmd", {8'h10, 8'hA2}, wq[wq.size() - 513]);
      for (int i = 0; i < 512; i++)
         chk("wr byte", {8'h13, 8'(i) ^ 8'h5A}, wq[wq.size() - 512 + i]);
   endtask
   task automatic t_fmt();
      int n;
      int k;
      eq = {};
      wq = {};
      hang <= 1'b1;
      add(50, 8'h4E); add(12, 8'h00); add(3, 8'hF6); add(1, 8'hFC);
      add(50, 8'h4E); add(12, 8'h00); add(3, 8'hF5); add(1, 8'hFE);
      add(1, 8'h07); add(1, 8'h01); add(1, 8'h01); add(1, 8'h02); add(1, 8'hF7);
      run(mk(OP_SELECT, 0, 1, 6), n);
      run(mk(OP_FORMAT, 7, 1, 5), n);
      k = 0;
      while (k < wq.size() && wq[k][15:8] !== 8'h10) k++;
      chk("track write", {8'h10, 8'hF0}, wq[k]);
      for (int i = 0; i < eq.size(); i++)
         chk("fmt byte", eq[i], wq[k + 1 + i]);
      chk("abort", {8'h10, 8'hD0}, wq[$]);
      chk("timeout", 1, status[7]);
      hang <= 1'b0;
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      req = '0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      t_pos();
      t_busy();
      t_rw();
      t_fmt();
      give_verdict();
   end
   // Watchdog
   initial begin
      #(8 * 60000);
      mismatches++;
      give_verdict();
   end
endmodule // tb_top
`default_nettype wire
